/* ods_pkg.sv */
// Package with the register map, field layout and reset values of the output status block.
package ods_pkg;
	// Register offsets on the control port.
	localparam logic [7:0] ODS_ADDR_RLO_CTRL = 8'h5d;
	localparam logic [7:0] ODS_ADDR_PWR_STATE = 8'h5e;
	localparam logic [7:0] ODS_ADDR_SHORT_STATE = 8'h5f;
	localparam logic [7:0] ODS_ADDR_LATCHED = 8'h60;
	localparam logic [7:0] ODS_ADDR_LIVE = 8'h61;
	// Field positions of the right line-output control register.
	localparam int unsigned ODS_LEVEL_MSB = 7;
	localparam int unsigned ODS_LEVEL_LSB = 4;
	localparam int unsigned ODS_MUTE_BIT = 3;
	localparam int unsigned ODS_SETTLED_BIT = 1;
	localparam int unsigned ODS_POWER_BIT = 0;
	// Values after reset.
	localparam logic [3:0] ODS_LEVEL_RST = 4'h0;
	localparam logic ODS_UNMUTE_RST = 1'b0;
	localparam logic ODS_POWER_RST = 1'b0;
	localparam logic [5:0] ODS_STICKY_RST = 6'h00;
	localparam logic [7:0] ODS_RDATA_RST = 8'h00;
	// Layout of the synchronised status vector from the analog side.
	localparam int unsigned ODS_STAT_W = 15;
	localparam int unsigned ODS_ST_PENDING = 14;
	localparam int unsigned ODS_ST_DAC_L = 13;
	localparam int unsigned ODS_ST_DAC_R = 12;
	localparam int unsigned ODS_ST_LO_L = 11;
	localparam int unsigned ODS_ST_LO_R = 10;
	localparam int unsigned ODS_ST_HP_L = 9;
	localparam int unsigned ODS_ST_HP_R = 8;
	localparam int unsigned ODS_ST_COM_L = 7;
	localparam int unsigned ODS_ST_COM_R = 6;
	// Bits 5..2 are the four short indications, bits 1..0 the noise gates.
	localparam int unsigned ODS_ST_SHORT_MSB = 5;
	localparam int unsigned ODS_ST_NOISE_MSB = 1;
	localparam logic [ODS_STAT_W-1:0] ODS_STAT_RST = 15'h0000;
endpackage : ods_pkg

/* ods_sync.sv */
// Two-flop synchroniser for a vector of independent status levels.
`timescale 1ns/1ps
`default_nettype none
module ods_sync
	import ods_pkg::*;
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [ODS_STAT_W-1:0] async_in,
	output logic [ODS_STAT_W-1:0] sync_out
);
	typedef struct packed {
		logic [ODS_STAT_W-1:0] first;
		logic [ODS_STAT_W-1:0] second;
	} ods_sync_state_t;

	ods_sync_state_t state;
	ods_sync_state_t next_state;

	// Each bit is crossed on its own, so bits of one event may land a cycle apart.
	always_comb
	begin
		next_state.first = async_in;
		next_state.second = state.first;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state.first <= ODS_STAT_RST;
			state.second <= ODS_STAT_RST;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign sync_out = state.second;
endmodule : ods_sync
`default_nettype wire

/* ods_regs.sv */
// Output driver control and status flag registers behind the control port.
// What this block does
// - Upper nibble of line-out control sets level, code equals dB from 0 to 9.
// - Bit 3 mutes the right line-out driver when zero; resets muted.
// - Read-only bit 1 reads zero while gain pending, one when settled; resets one.
// - Bit 0 powers the right line-out driver fully when one; resets zero.
// - Power register bits 7 and 6 show left and right converter power.
// - Power register bits 4 to 1 show line-out and headphone driver power.
// - Short register bits 7 to 4 show shorts at the four headphone drivers.
// - Short register bits 3 and 2 show common driver power state.
// - Sticky register holds short events of the four drivers in bits 7 to 4.
// - Bits 1 and 0 of both flag registers show noise gate state.
// - Live flag register shows present conditions in the sticky layout.
`timescale 1ns/1ps
`default_nettype none
module ods_regs
	import ods_pkg::*;
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_in,
	// Register access port.
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Analog status levels, asynchronous to the clock.
	input wire logic gain_pending_in,
	input wire logic [1:0] dac_powered_in,
	input wire logic [1:0] line_out_powered_in,
	input wire logic [1:0] headphone_powered_in,
	input wire logic [1:0] common_powered_in,
	input wire logic [3:0] short_detect_in,
	input wire logic [1:0] noise_gate_in,
	// Controls to the right line-out driver.
	output logic [3:0] right_line_out_level_out,
	output logic right_line_out_unmute_out,
	output logic right_line_out_power_out
);
	typedef struct packed {
		logic [3:0] level;
		logic unmute;
		logic power_up;
		logic [5:0] sticky;
		logic [7:0] rdata;
		logic rvalid;
	} ods_regs_state_t;

	ods_regs_state_t state;
	ods_regs_state_t next_state;
	logic [ODS_STAT_W-1:0] stat;
	logic [5:0] live;
	logic wr_ctrl;
	logic rd_sticky;

	// Places a six-bit flag set into the shared flag byte layout.
	function automatic logic [7:0] ods_flag_byte(input logic [5:0] flags);
		ods_flag_byte = {flags[5:2], 2'b00, flags[1:0]};
	endfunction : ods_flag_byte

	ods_sync u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in({gain_pending_in, dac_powered_in, line_out_powered_in,
			headphone_powered_in, common_powered_in, short_detect_in, noise_gate_in}),
		.sync_out(stat)
	);

	assign live = stat[ODS_ST_SHORT_MSB:0];
	assign wr_ctrl = reg_wr_in && (reg_addr_in == ODS_ADDR_RLO_CTRL);
	assign rd_sticky = reg_rd_in && (reg_addr_in == ODS_ADDR_LATCHED);

	always_comb
	begin
		next_state = state;
		next_state.rvalid = reg_rd_in;
		// Level codes above nine are the host's to avoid; they are stored as written.
		if (wr_ctrl)
		begin
			next_state.level = reg_wdata_in[ODS_LEVEL_MSB:ODS_LEVEL_LSB];
			next_state.unmute = reg_wdata_in[ODS_MUTE_BIT];
			next_state.power_up = reg_wdata_in[ODS_POWER_BIT];
		end
		// A new event in the clearing read cycle is kept, so no short goes unseen.
		if (rd_sticky)
		begin
			next_state.sticky = live;
		end
		else
		begin
			next_state.sticky = state.sticky | live;
		end
		if (reg_rd_in)
		begin
			if (reg_addr_in == ODS_ADDR_RLO_CTRL)
			begin
				next_state.rdata = {state.level, state.unmute, 1'b0,
					!stat[ODS_ST_PENDING], state.power_up};
			end
			else if (reg_addr_in == ODS_ADDR_PWR_STATE)
			begin
				next_state.rdata = {stat[ODS_ST_DAC_L], stat[ODS_ST_DAC_R], 1'b0,
					stat[ODS_ST_LO_L], stat[ODS_ST_LO_R], stat[ODS_ST_HP_L],
					stat[ODS_ST_HP_R], 1'b0};
			end
			else if (reg_addr_in == ODS_ADDR_SHORT_STATE)
			begin
				next_state.rdata = {stat[ODS_ST_SHORT_MSB:2], stat[ODS_ST_COM_L],
					stat[ODS_ST_COM_R], 2'b00};
			end
			else if (reg_addr_in == ODS_ADDR_LATCHED)
			begin
				next_state.rdata = ods_flag_byte(state.sticky);
			end
			else if (reg_addr_in == ODS_ADDR_LIVE)
			begin
				next_state.rdata = ods_flag_byte(live);
			end
			else
			begin
				next_state.rdata = ODS_RDATA_RST;
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state.level <= ODS_LEVEL_RST;
			state.unmute <= ODS_UNMUTE_RST;
			state.power_up <= ODS_POWER_RST;
			state.sticky <= ODS_STICKY_RST;
			state.rdata <= ODS_RDATA_RST;
			state.rvalid <= 1'b0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign reg_rdata_out = state.rdata;
	assign reg_rvalid_out = state.rvalid;
	assign right_line_out_level_out = state.level;
	assign right_line_out_unmute_out = state.unmute;
	assign right_line_out_power_out = state.power_up;

	default clocking ods_clk @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	AST_LEVEL_WRITE: assert property (wr_ctrl |=> right_line_out_level_out == $past(reg_wdata_in[7:4]))
		else $error("Level field did not follow the write.");
	AST_MUTE_HOLD: assert property (!wr_ctrl |=> $stable(right_line_out_unmute_out))
		else $error("Mute changed without a control write.");
	AST_MUTE_READBACK: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_RLO_CTRL
		|=> reg_rdata_out[3] == $past(right_line_out_unmute_out) && !reg_rdata_out[2])
		else $error("Mute read-back wrong.");
	AST_SETTLED: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_RLO_CTRL
		|=> reg_rdata_out[1] == !$past(stat[ODS_ST_PENDING]))
		else $error("Gain settled bit wrong.");
	AST_POWER_WRITE: assert property (wr_ctrl |=> right_line_out_power_out == $past(reg_wdata_in[0]))
		else $error("Power bit did not follow the write.");
	AST_PWR_STATE: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_PWR_STATE
		|=> reg_rdata_out[7:6] == $past(stat[13:12]) && reg_rdata_out[4:1] == $past(stat[11:8])
		&& !reg_rdata_out[5] && !reg_rdata_out[0])
		else $error("Power state read wrong.");
	AST_SHORT_STATE: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_SHORT_STATE
		|=> reg_rdata_out == {$past(stat[5:2]), $past(stat[7:6]), 2'b00})
		else $error("Short state read wrong.");
	AST_STICKY_HOLD: assert property (!rd_sticky |=> (state.sticky & $past(state.sticky))
		== $past(state.sticky))
		else $error("Sticky flag lost without a read.");
	AST_STICKY_CLEAR: assert property (rd_sticky ##1 !rd_sticky[*2]
		|-> state.sticky == ($past(live, 2) | $past(live)))
		else $error("Sticky flags not cleared by read.");
	AST_LIVE_READ: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_LIVE
		|=> reg_rdata_out == {$past(live[5:2]), 2'b00, $past(live[1:0])} && reg_rvalid_out)
		else $error("Live flag read wrong.");

	// These hold, read-back and pulse checks guard behaviour that the bench only samples now and then.
	AST_LEVEL_HOLD: assert property (!wr_ctrl |=> $stable(right_line_out_level_out))
		else $error("Level changed without a control write.");
	AST_POWER_HOLD: assert property (!wr_ctrl |=> $stable(right_line_out_power_out))
		else $error("Power control changed without a control write.");
	AST_CTRL_READBACK: assert property (reg_rd_in && reg_addr_in == ODS_ADDR_RLO_CTRL
		|=> reg_rdata_out[7:4] == $past(right_line_out_level_out)
		&& reg_rdata_out[0] == $past(right_line_out_power_out))
		else $error("Level or power read-back wrong.");
	AST_RVALID_PULSE: assert property (1'b1 |=> reg_rvalid_out == $past(reg_rd_in))
		else $error("Read valid is not a one-cycle echo of the read strobe.");
	// A live event in the clearing read cycle must still land, so the set side wins.
	AST_STICKY_SET: assert property (live != 6'h00
		|=> (state.sticky & $past(live)) == $past(live))
		else $error("Live event missing from the sticky flags.");
	AST_LATCHED_READ: assert property (rd_sticky
		|=> reg_rdata_out == {$past(state.sticky[5:2]), 2'b00, $past(state.sticky[1:0])})
		else $error("Sticky flag read wrong.");
	AST_FLAG_RSVD: assert property (reg_rd_in
		&& (reg_addr_in == ODS_ADDR_LATCHED || reg_addr_in == ODS_ADDR_LIVE)
		|=> reg_rdata_out[3:2] == 2'b00)
		else $error("Reserved flag bits read non-zero.");

	// The covers mark the scenarios that the bench is meant to reach.
	COV_CTRL_WRITE: cover property (wr_ctrl ##1 right_line_out_unmute_out);
	COV_STICKY_READ: cover property (state.sticky != 6'h00 ##1 rd_sticky);
	COV_SHORT_EVENT: cover property (live[5:2] != 4'h0 ##1 live[5:2] == 4'h0);
	COV_PENDING_READ: cover property (stat[ODS_ST_PENDING] && reg_rd_in
		&& reg_addr_in == ODS_ADDR_RLO_CTRL);
	COV_NOISE_READ: cover property (reg_rd_in && reg_addr_in == ODS_ADDR_LIVE
		&& live[1:0] != 2'b00);
endmodule : ods_regs
`default_nettype wire

/* ods_host.sv */
// Host model that drives the register port of the output status block.
`timescale 1ns/1ps
`default_nettype none
module ods_host
(
	// Clock.
	input wire logic clock_in,
	// Register access port.
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_rvalid_in
);
	initial
	begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_out = 1'b0;
	end
	// Status registers are never written, so such requests are dropped here.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d & 8'hfb;
		if (v[7:4] > 4'h9)
			v[7:4] = 4'h9;
		if (a >= 8'h5e && a <= 8'h61)
			return;
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_wdata_out <= v;
		reg_wr_out <= 1'b1;
		@(posedge clock_in);
		reg_wr_out <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clock_in);
		reg_rd_out <= 1'b0;
		#1;
		ok = reg_rvalid_in;
		d = reg_rdata_in;
	endtask : rd
endmodule : ods_host
`default_nettype wire

/* output_driver_status_flags_bench.sv */
// Self-checking bench for the output status register block.
`timescale 1ns/1ps
`default_nettype none
module output_driver_status_flags_bench;
	import ods_pkg::*;
	logic clock_in, rst_in, wr, rd, rv, pend, ok, unm, pwr;
	logic [7:0] addr, wd, rdat, d;
	logic [1:0] dac, lo, hp, com, noise;
	logic [3:0] shrt, lvl, lv;
	int n_mismatch, checked, cycles;
	ods_regs ods_regs_i (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.reg_rvalid_out(rv), .gain_pending_in(pend), .dac_powered_in(dac),
		.line_out_powered_in(lo), .headphone_powered_in(hp), .common_powered_in(com),
		.short_detect_in(shrt), .noise_gate_in(noise), .right_line_out_level_out(lvl),
		.right_line_out_unmute_out(unm), .right_line_out_power_out(pwr));
	ods_host ods_host_i (.clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
		.reg_wdata_out(wd), .reg_rd_out(rd), .reg_rdata_in(rdat), .reg_rvalid_in(rv));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8
	task automatic chk6(input logic [5:0] e);
		#1;
		checked++;
		if ({lvl, unm, pwr} !== e)
		begin
			n_mismatch++;
			$display("FAIL driver controls expected %h seen %h", e, {lvl, unm, pwr});
		end
	endtask : chk6
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		ods_host_i.rd(a, d, ok);
		chk8("read valid", 8'h01, {7'h00, ok});
		chk8($sformatf("register %h", a), e, d);
	endtask : rchk
	// Two synchroniser edges plus margin before status is read back.
	task automatic set_stat(input logic [14:0] v);
		@(posedge clock_in);
		{pend, dac, lo, hp, com, shrt, noise} <= v;
		repeat (4) @(posedge clock_in);
	endtask : set_stat
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	initial
	begin
		rst_in = 1'b1;
		{pend, dac, lo, hp, com, shrt, noise} = 15'h0000;
		n_mismatch = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		chk6(6'h00);
		rchk(ODS_ADDR_RLO_CTRL, 8'h02);
		for (int i = 0; i < 10; i++)
		begin
			lv = 4'(i);
			ods_host_i.wr(ODS_ADDR_RLO_CTRL, {lv, lv[0], 2'b00, ~lv[0]});
			chk6({lv, lv[0], ~lv[0]});
			rchk(ODS_ADDR_RLO_CTRL, {lv, lv[0], 2'b01, ~lv[0]});
		end
		set_stat(15'h4000);
		rchk(ODS_ADDR_RLO_CTRL, 8'h98);
		set_stat({1'b0, 2'b10, 2'b01, 2'b10, 2'b01, 4'b1010, 2'b00});
		rchk(ODS_ADDR_PWR_STATE, 8'h8c);
		rchk(ODS_ADDR_SHORT_STATE, 8'ha4);
		set_stat({1'b0, 2'b01, 2'b10, 2'b01, 2'b10, 4'b0101, 2'b00});
		rchk(ODS_ADDR_PWR_STATE, 8'h52);
		rchk(ODS_ADDR_SHORT_STATE, 8'h58);
		rchk(ODS_ADDR_RLO_CTRL, 8'h9a);
		rchk(ODS_ADDR_LATCHED, 8'hf0);
		set_stat(15'h0000);
		rchk(ODS_ADDR_LIVE, 8'h00);
		rchk(ODS_ADDR_LATCHED, 8'h50);
		rchk(ODS_ADDR_LATCHED, 8'h00);
		set_stat({9'h000, 4'b1000, 2'b01});
		rchk(ODS_ADDR_LIVE, 8'h81);
		set_stat(15'h0000);
		rchk(ODS_ADDR_LIVE, 8'h00);
		rchk(ODS_ADDR_LATCHED, 8'h81);
		rchk(ODS_ADDR_LATCHED, 8'h00);
		// A reset in mid-run must drop latched events and driver settings alike.
		ods_host_i.wr(ODS_ADDR_RLO_CTRL, 8'h39);
		chk6(6'h0f);
		set_stat({9'h000, 4'b0010, 2'b10});
		set_stat(15'h0000);
		@(posedge clock_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		chk6(6'h00);
		rchk(ODS_ADDR_LATCHED, 8'h00);
		rchk(ODS_ADDR_RLO_CTRL, 8'h02);
		rchk(8'h62, 8'h00);
		stop_test();
	end
endmodule : output_driver_status_flags_bench
`default_nettype wire
